// file: design/snhi_device.sv
`timescale 1ns/10ps
// Contract
// - Clock mode 0 or mode 3 only
// - Sample on rising, shift on falling edge
// - Host parks clock while deselected
// - Deselected with parked clock means idle
// - Dual commands use lines 0 and 1
// - Quad commands use all four lines
// - DTR quad read outputs both edges
// - Strobe driven with DTR read data
// - DTR quad needs quad enable set
// - Pause only while quad enable clear
// - Pause stops link, not array work
// - Pause starts on hold fall, clock low
// - Pause ends on hold rise, clock low
// - Paused: outputs off, inputs ignored
// - Deselect during pause resets interface
// - Host raises hold before reselecting
// - Guard plus protect low locks protection
// - Protect pin works only with quad clear
// - Column 12 bits, valid up to 2175
// - Row page bits 5:0, block 16:6
// - 2048 blocks of 64 pages
// - ECC on limits spare programming
// - ECC enabled after power-up
module snhi_device (
  input wire logic pclk,
  input wire logic presetn,
  snhi_if.device link,
  input wire logic [1:0] xfer_width,
  input wire logic out_en,
  input wire logic [7:0] tx_byte,
  input wire logic prot_wr,
  input wire logic [7:0] prot_wdata,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [11:0] column_addr,
  input wire logic [16:0] row_addr,
  input wire logic array_busy,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic tx_taken,
  output logic [7:0] prot_reg,
  output logic [7:0] cfg_reg,
  output logic paused,
  output logic mode3,
  output logic col_valid,
  output logic spare_prog_ok,
  output logic [5:0] page_sel,
  output logic [10:0] block_sel,
  output logic array_busy_seen
);
  typedef struct packed {
    logic sclk_d;
    logic sel;
    logic mode3;
    logic pause;
    logic pause_pend;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] txs;
    logic [3:0] dout;
    logic [3:0] oe;
    logic dqs;
    logic [7:0] rx;
    logic rxv;
    logic tk;
    logic [7:0] prot;
    logic [7:0] cfg;
  } snhi_dev_type;
  snhi_dev_type st_r, st_nxt;
  logic [6:0] pins;
  logic sclk_s, cs_n_s;
  logic [3:0] din_s;
  logic hold_n_s;

  snhi_sync #(.W(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.sclk, link.cs_n, link.line_in, link.line_in[3]}),
    .q(pins)
  );
  assign sclk_s = pins[6];
  assign cs_n_s = pins[5];
  assign din_s = pins[4:1];
  assign hold_n_s = pins[0];

  // Bits moved per clock edge for the chosen width
  function automatic logic [3:0] step(input logic [1:0] w);
    case (w)
      2'd1: step = 4'd2;
      2'd2, 2'd3: step = 4'd4;
      default: step = 4'd1;
    endcase
  endfunction

  // Driven lines, enables and remaining bits after one output step, MSB first
  function automatic logic [15:0] emit(input logic [7:0] t, input logic [3:0] k);
    case (k)
      4'd4: emit = {t[7:4], 4'hF, t[3:0], 4'h0};
      4'd2: emit = {2'b00, t[7:6], 4'h3, t[5:0], 2'b00};
      default: emit = {2'b00, t[7], 1'b0, 4'h2, t[6:0], 1'b0};
    endcase
  endfunction

  logic qe, rise, fall, dtr, wp_lock, hold_fn;
  assign qe = st_r.cfg[snhi_pkg::QE_POS];
  assign rise = sclk_s && !st_r.sclk_d;
  assign fall = !sclk_s && st_r.sclk_d;
  assign dtr = (xfer_width == 2'd3) && qe;
  assign hold_fn = !qe;
  // Hardware lock only honoured while quad lines are not in use
  assign wp_lock = st_r.prot[snhi_pkg::PROT_GUARD_POS] && !din_s[2] && !qe;

  // Link state machine; the array side keeps running during a pause
  always_comb begin
    logic [3:0] n;
    n = step(xfer_width);
    st_nxt = st_r;
    st_nxt.sclk_d = sclk_s;
    st_nxt.rxv = 1'b0;
    st_nxt.tk = 1'b0;
    // Protection and configuration writes from the command layer
    if (prot_wr && !wp_lock) begin
      st_nxt.prot = prot_wdata;
    end
    if (cfg_wr) begin
      st_nxt.cfg = cfg_wdata;
    end
    if (cs_n_s) begin
      // Deselect clears the link, paused or not
      st_nxt.sel = 1'b0;
      st_nxt.pause = 1'b0;
      st_nxt.pause_pend = 1'b0;
      st_nxt.cnt = '0;
      st_nxt.oe = '0;
      st_nxt.dqs = 1'b0;
    end else if (!st_r.sel) begin
      st_nxt.sel = 1'b1;
      st_nxt.mode3 = sclk_s;
      st_nxt.txs = tx_byte;
      st_nxt.tk = 1'b1;
      // Mode 0 has no falling edge before the first sample, so lead with the first bits
      if (out_en && !sclk_s) begin
        {st_nxt.dout, st_nxt.oe, st_nxt.txs} = emit(tx_byte, n);
      end
    end else begin
      // Pause enters or leaves only with the clock low
      st_nxt.pause_pend = hold_fn && !hold_n_s;
      if (!sclk_s) begin
        st_nxt.pause = hold_fn && !hold_n_s;
      end
      if (st_r.pause) begin
        st_nxt.oe = '0;
      end else begin
        if (rise) begin
          // Capture on the rising edge
          case (n)
            4'd4: st_nxt.sh = {st_r.sh[3:0], din_s};
            4'd2: st_nxt.sh = {st_r.sh[5:0], din_s[1:0]};
            default: st_nxt.sh = {st_r.sh[6:0], din_s[0]};
          endcase
          st_nxt.cnt = st_r.cnt + n;
          if (st_r.cnt + n >= 4'd8) begin
            st_nxt.cnt = '0;
            st_nxt.rxv = !out_en;
            st_nxt.rx = (n == 4'd4) ? {st_r.sh[3:0], din_s}
              : (n == 4'd2) ? {st_r.sh[5:0], din_s[1:0]} : {st_r.sh[6:0], din_s[0]};
          end
        end
        if (out_en && (fall || (dtr && rise))) begin
          // Shift out on falling edge; both edges in DTR
          st_nxt.dqs = dtr ? !st_r.dqs : 1'b0;
          {st_nxt.dout, st_nxt.oe, st_nxt.txs} = emit(st_r.txs, n);
          if (st_r.txs[7:0] == 8'h0_0 || st_r.cnt == 4'd0) begin
            st_nxt.tk = 1'b0;
          end
        end
      end
    end
    // Reload next outgoing byte at byte boundary
    if (!cs_n_s && st_r.sel && !st_r.pause && rise && out_en && (st_r.cnt + n >= 4'd8)) begin
      st_nxt.txs = tx_byte;
      st_nxt.tk = 1'b1;
    end
    if (!out_en && !cs_n_s) begin
      st_nxt.oe = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.sclk_d <= 1'b0;
      st_r.cfg <= snhi_pkg::CFG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.dev_dout = st_r.dout;
  assign link.dev_oe = st_r.oe;
  assign link.dqs = st_r.dqs;
  assign rx_byte = st_r.rx;
  assign rx_valid = st_r.rxv;
  assign tx_taken = st_r.tk;
  assign prot_reg = st_r.prot;
  assign cfg_reg = st_r.cfg;
  assign paused = st_r.pause;
  assign mode3 = st_r.mode3;
  assign array_busy_seen = array_busy;
  // Address decode for the array
  assign col_valid = column_addr <= snhi_pkg::COL_LAST;
  assign page_sel = row_addr[snhi_pkg::PAGE_MSB:snhi_pkg::PAGE_LSB];
  assign block_sel = row_addr[snhi_pkg::BLOCK_MSB:snhi_pkg::BLOCK_LSB];
  // Spare area above main bytes: only first part writable with ECC on
  assign spare_prog_ok = col_valid && (!st_r.cfg[snhi_pkg::ECC_POS]
    || column_addr < snhi_pkg::MAIN_BYTES + snhi_pkg::SPARE_PROG_ECC);
endmodule

// file: design/snhi_pkg.sv
package snhi_pkg;
  // Addressing layout
  localparam int COL_W = 12;
  localparam logic [11:0] COL_LAST = 12'h0_87F; // 2175, last byte of a page
  localparam int ROW_W = 17;
  localparam int PAGE_LSB = 0;
  localparam int PAGE_MSB = 5;
  localparam int BLOCK_LSB = 6;
  localparam int BLOCK_MSB = 16;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS = 2048;
  localparam logic [11:0] MAIN_BYTES = 12'h0_800;
  localparam logic [11:0] SPARE_PROG_ECC = 12'h0_040; // Spare bytes writable with ECC on
  localparam logic [11:0] SPARE_BYTES = 12'h0_080;
  // Protection register fields (feature register A0-like layout, local choice)
  localparam int PROT_GUARD_POS = 7;
  localparam int PROT_W = 5;
  // Configuration fields (B0)
  localparam int QE_POS = 0;
  localparam int ECC_POS = 4;
  localparam logic [7:0] CFG_RESET = 8'h1_0; // ECC enabled by default
  // Transfer widths
  typedef enum logic [1:0] {SNHI_X1, SNHI_X2, SNHI_X4, SNHI_X4DTR} snhi_width_type;
  // APB register offsets of the host controller
  localparam logic [7:0] REG_CTRL = 8'h0_0;
  localparam logic [7:0] REG_TXDATA = 8'h0_4;
  localparam logic [7:0] REG_RXDATA = 8'h0_8;
  localparam logic [7:0] REG_STATUS = 8'h0_C;
  localparam logic [7:0] REG_DIV = 8'h1_0;
  localparam logic [7:0] DIV_RESET = 8'h0_4; // Half-period in pclk cycles
  // Host control bits
  localparam int CTL_GO = 0;
  localparam int CTL_CS = 1;
  localparam int CTL_MODE3 = 2;
  localparam int CTL_WLSB = 3;
  localparam int CTL_DIR = 5; // 1 = read from device
  localparam int CTL_HOLD = 6;
  localparam int CTL_WP = 7;
  localparam int CTL_QE = 8;
endpackage

// file: design/snhi_if.sv
`timescale 1ns/10ps
// Pins between host and serial NAND device; lines resolved from enables
interface snhi_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_dout;
  logic [3:0] host_oe;
  logic [3:0] dev_dout;
  logic [3:0] dev_oe;
  logic [3:0] line_in;
  logic dqs;
  // Resolved wire level, pull-up when nobody drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (host_oe[i]) begin
        line_in[i] = host_dout[i];
      end else if (dev_oe[i]) begin
        line_in[i] = dev_dout[i];
      end else begin
        line_in[i] = 1'b1;
      end
    end
  end
  modport host (output sclk, output cs_n, output host_dout, output host_oe,
    input line_in, input dqs);
  modport device (input sclk, input cs_n, output dev_dout, output dev_oe,
    input line_in, output dqs);
endinterface

// file: design/snhi_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for pin inputs
module snhi_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } snhi_sync_type;
  snhi_sync_type st_r, st_nxt;

  // First stage feeds only the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// file: design/snhi_host.sv
`timescale 1ns/10ps
// Host controller: APB slave that drives the serial link one byte per order
module snhi_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  snhi_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} snhi_hst_type;
  typedef struct packed {
    snhi_hst_type fsm;
    logic [8:0] ctl;
    logic [7:0] div;
    logic [7:0] dcnt;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] bits;
    logic sclk;
    logic busy;
  } snhi_hs_type;
  snhi_hs_type st_r, st_nxt;
  logic [3:0] din_s;

  snhi_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.line_in),
    .q(din_s)
  );

  logic wr, rd, quad_ok;
  logic [3:0] n;
  logic [3:0] adv;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign n = (st_r.ctl[4:3] == 2'd0) ? 4'd1 : (st_r.ctl[4:3] == 2'd1) ? 4'd2 : 4'd4;
  // Double rate moves a nibble on each edge, so a byte per clock period
  assign adv = (st_r.ctl[4:3] == 2'd3) ? 4'd8 : n;
  // Quad widths refused unless quad enable mirrored
  assign quad_ok = !(pwdata[4] && !pwdata[snhi_pkg::CTL_QE]);

  // Divider-driven clock and APB register writes
  always_comb begin
    st_nxt = st_r;
    if (wr) begin
      case (paddr)
        snhi_pkg::REG_CTRL: begin
          if (quad_ok && !st_r.busy) begin
            // Hold released before select may fall
            st_nxt.ctl = pwdata[8:0];
            st_nxt.ctl[snhi_pkg::CTL_CS] = pwdata[snhi_pkg::CTL_CS] | !pwdata[snhi_pkg::CTL_HOLD];
            st_nxt.busy = pwdata[snhi_pkg::CTL_GO];
            st_nxt.bits = '0;
          end
        end
        snhi_pkg::REG_TXDATA: st_nxt.tx = pwdata[7:0];
        snhi_pkg::REG_DIV: st_nxt.div = (pwdata[7:0] == 8'h0_0) ? 8'h0_1 : pwdata[7:0];
        default: ;
      endcase
    end
    case (st_r.fsm)
      H_IDLE: begin
        // Park level follows the new order, so it moves in the cycle any control write is taken, select or not
        st_nxt.sclk = st_nxt.ctl[snhi_pkg::CTL_MODE3];
        st_nxt.dcnt = '0;
        if (st_r.busy && !st_r.ctl[snhi_pkg::CTL_CS]) begin
          st_nxt.fsm = H_LOW;
          st_nxt.sclk = 1'b0;
        end
      end
      H_LOW: begin
        st_nxt.dcnt = st_r.dcnt + 8'h0_1;
        if (st_r.dcnt + 8'h0_1 >= st_r.div) begin
          // Rising edge: sample incoming lines
          st_nxt.dcnt = '0;
          st_nxt.sclk = 1'b1;
          st_nxt.fsm = H_HIGH;
          case (n)
            4'd4: st_nxt.rx = {st_r.rx[3:0], din_s};
            4'd2: st_nxt.rx = {st_r.rx[5:0], din_s[1:0]};
            default: st_nxt.rx = {st_r.rx[6:0], din_s[1]};
          endcase
        end
      end
      H_HIGH: begin
        st_nxt.dcnt = st_r.dcnt + 8'h0_1;
        if (st_r.dcnt + 8'h0_1 >= st_r.div) begin
          // Falling edge: shift outgoing data; double rate also samples here
          st_nxt.dcnt = '0;
          st_nxt.sclk = 1'b0;
          st_nxt.bits = st_r.bits + adv;
          st_nxt.tx = st_r.tx << n;
          st_nxt.fsm = H_LOW;
          if (st_r.ctl[4:3] == 2'd3) begin
            st_nxt.rx = {st_r.rx[3:0], din_s};
          end
          if (st_r.bits + adv >= 4'd8) begin
            st_nxt.busy = 1'b0;
            st_nxt.fsm = H_IDLE;
            st_nxt.sclk = st_r.ctl[snhi_pkg::CTL_MODE3];
          end
        end
      end
      default: st_nxt.fsm = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.fsm <= H_IDLE;
      st_r.ctl <= 9'h0_C2; // Deselected, hold and protect high
      st_r.div <= snhi_pkg::DIV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drive: quad lines replace protect and hold pins
  always_comb begin
    link.host_dout = 4'h0;
    link.host_oe = 4'h0;
    link.host_dout[2] = st_r.ctl[snhi_pkg::CTL_WP];
    link.host_dout[3] = st_r.ctl[snhi_pkg::CTL_HOLD];
    link.host_oe[3:2] = 2'b11;
    if (!st_r.ctl[snhi_pkg::CTL_DIR]) begin
      link.host_oe[0] = 1'b1;
      link.host_dout[0] = st_r.tx[7];
      if (n == 4'd2) begin
        link.host_dout[1:0] = st_r.tx[7:6];
        link.host_oe[1] = 1'b1;
      end
      if (n == 4'd4) begin
        link.host_dout = st_r.tx[7:4];
        link.host_oe = 4'hF;
      end
    end else if (n != 4'd1) begin
      link.host_oe = (n == 4'd4) ? 4'h0 : 4'hC;
    end
    // Deselected, lines 2 and 3 are protect and hold pins again
    if (st_r.ctl[snhi_pkg::CTL_CS]) begin
      link.host_dout[3:2] = {st_r.ctl[snhi_pkg::CTL_HOLD], st_r.ctl[snhi_pkg::CTL_WP]};
      link.host_oe[3:2] = 2'b11;
    end
  end

  assign link.sclk = st_r.sclk;
  assign link.cs_n = st_r.ctl[snhi_pkg::CTL_CS];
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  // Read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        snhi_pkg::REG_CTRL: prdata = {23'h0, st_r.ctl};
        snhi_pkg::REG_TXDATA: prdata = {24'h0, st_r.tx};
        snhi_pkg::REG_RXDATA: prdata = {24'h0, st_r.rx};
        snhi_pkg::REG_STATUS: prdata = {31'h0, st_r.busy};
        snhi_pkg::REG_DIV: prdata = {24'h0, st_r.div};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// file: test/snhi_link_asserts.sv
`timescale 1ns/10ps
// Pin-level checks between the two ends; sees the shared wires plus each end's drive and enable
module snhi_link_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_dout,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_dout,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] line_in,
  input wire logic dqs
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A parked clock must not move, so mode is only changed together with a select
  property p_park;
    cs_n && $past(cs_n) |-> $stable(sclk);
  endproperty
  a_park: assert property (p_park) else $error("clock moved while deselected");
  // Allow a few cycles for the deselect to cross the synchroniser
  property p_idle;
    cs_n [*5] |-> dev_oe == 4'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("device drives while idle");
  property p_lanes;
    dev_oe != 4'h0 |-> dev_oe inside {4'h2, 4'h3, 4'hf};
  endproperty
  a_lanes: assert property (p_lanes) else $error("odd set of driven lines");
  property p_no_fight;
    !cs_n |-> (host_oe & dev_oe) == 4'h0;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive a line");
  // Device output moves between clock edges, never on one, in all rates
  property p_dev_edge;
    !cs_n && dev_oe != 4'h0 && $changed(sclk) |-> $stable(dev_dout);
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved at edge");
  property p_host_edge;
    !cs_n && $rose(sclk) |-> $stable(host_dout);
  endproperty
  a_host_edge: assert property (p_host_edge) else $error("host data moved at rise");
  property p_strobe;
    !cs_n && $changed(dqs) |-> dev_oe == 4'hf || $past(dev_oe) == 4'hf;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without quad data");
  property p_hold_high;
    $fell(cs_n) |-> $past(line_in[3]);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("selected with hold low");
  property p_clock_runs;
    $fell(cs_n) |-> ##[1:40] $changed(sclk);
  endproperty
  a_clock_runs: assert property (p_clock_runs) else $error("no clock after select");
endmodule

// file: test/tb_serial_nand_host_interface.sv
`timescale 1ns/10ps
// Host and device back to back; APB drives the host, device user side driven here
module tb_serial_nand_host_interface;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, tx_taken, paused, mode3, col_valid, spare_prog_ok;
  logic array_busy_seen, m3_seen;
  logic [1:0] xfer_width = 2'h0;
  logic out_en = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic prot_wr = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] prot_wdata = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [11:0] column_addr = 12'h000;
  logic [16:0] row_addr = 17'h0_0000;
  logic array_busy = 1'b0;
  logic [7:0] rx_byte, prot_reg, cfg_reg, rx_last;
  logic [5:0] page_sel;
  logic [10:0] block_sel;
  logic [15:0] seed = 16'h000a;
  logic [11:0] corners [8] = '{12'h000, 12'h7ff, 12'h800, 12'h83f, 12'h840, 12'h87f,
    12'h880, 12'hfff};
  int num_errors = 0;
  int checks_done = 0;

  always #12.5 pclk = ~pclk;

  snhi_if link_if ();
  snhi_host snhi_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  snhi_device snhi_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if),
    .xfer_width(xfer_width), .out_en(out_en), .tx_byte(tx_byte), .prot_wr(prot_wr),
    .prot_wdata(prot_wdata), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .column_addr(column_addr), .row_addr(row_addr), .array_busy(array_busy),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_taken(tx_taken), .prot_reg(prot_reg),
    .cfg_reg(cfg_reg), .paused(paused), .mode3(mode3), .col_valid(col_valid),
    .spare_prog_ok(spare_prog_ok), .page_sel(page_sel), .block_sel(block_sel),
    .array_busy_seen(array_busy_seen));
  snhi_link_asserts snhi_link_asserts_inst (.pclk(pclk), .presetn(presetn),
    .sclk(link_if.sclk), .cs_n(link_if.cs_n), .host_dout(link_if.host_dout),
    .host_oe(link_if.host_oe), .dev_dout(link_if.dev_dout), .dev_oe(link_if.dev_oe),
    .line_in(link_if.line_in), .dqs(link_if.dqs));

  // Last received byte, and the mode the device saw while selected
  always @(posedge pclk) begin
    if (rx_valid === 1'b1) begin
      rx_last <= rx_byte;
    end
    if (link_if.cs_n === 1'b0) begin
      m3_seen <= mode3;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Control word: go, select, mode 3, width, read, hold kept high, protect pin, quad
  function automatic logic [31:0] ctl(input logic go, input logic cs, input logic m3,
      input logic [1:0] w, input logic rd, input logic wp, input logic qe);
    return {23'h00_0000, qe, wp, 1'b1, rd, w, m3, cs, go};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; the idle edge at the end keeps back-to-back calls apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    apb(1'b1, a, d, unused);
  endtask

  task automatic dev_set(input logic is_cfg, input logic [7:0] d);
    cfg_wdata <= d;
    prot_wdata <= d;
    cfg_wr <= is_cfg;
    prot_wr <= !is_cfg;
    @(posedge pclk);
    cfg_wr <= 1'b0;
    prot_wr <= 1'b0;
    @(posedge pclk);
  endtask

  // One byte over the link, device set to the same width and direction first
  task automatic xfer(input logic m3, input logic [1:0] w, input logic rd, input logic [7:0] b);
    logic [31:0] v;
    xfer_width <= w;
    out_en <= rd;
    tx_byte <= b;
    wr(snhi_pkg::REG_TXDATA, {24'h00_0000, b});
    wr(snhi_pkg::REG_CTRL, ctl(1'b1, 1'b0, m3, w, rd, 1'b1, w[1]));
    v = 32'h0000_0001;
    for (int i = 0; i < 200 && v[0] !== 1'b0; i++) begin
      apb(1'b0, snhi_pkg::REG_STATUS, 32'h0000_0000, v);
    end
    check(v[0], 1'b0, "busy never cleared");
    wr(snhi_pkg::REG_CTRL, ctl(1'b0, 1'b1, m3, w, rd, 1'b1, w[1]));
    out_en <= 1'b0;
    if (rd) begin
      apb(1'b0, snhi_pkg::REG_RXDATA, 32'h0000_0000, v);
      check(v[7:0], b, "byte read");
    end else begin
      check(rx_last, b, "byte written");
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    logic [31:0] v;
    logic [11:0] c;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(cfg_reg, snhi_pkg::CFG_RESET, "config reset");
    check(prot_reg, 8'h00, "protect reset");
    check(link_if.cs_n, 1'b1, "select idle");
    apb(1'b0, snhi_pkg::REG_DIV, 32'h0000_0000, v);
    check(v, snhi_pkg::DIV_RESET, "divider reset");
    apb(1'b0, 8'h40, 32'h0000_0000, v);
    check(pslverr, 1'b0, "unmapped access");
    wr(snhi_pkg::REG_DIV, 32'h0000_0008);
    $display("test reset done");
    // Every width both ways except DTR quad, which is read only, corner bytes first, then random ones
    for (int k = 0; k < 32; k++) begin
      seed = lfsr(seed);
      if (k[1:0] != 2'h3 || k[2]) begin
        dev_set(1'b1, k[1] ? 8'h11 : 8'h10);
        xfer(1'b0, k[1:0], k[2], (k < 16) ? (k[3] ? 8'h81 : 8'h7e) : seed[7:0]);
      end
    end
    check(m3_seen, 1'b0, "mode 0 seen");
    $display("test widths done");
    // Quad order without the quad bit is dropped
    dev_set(1'b1, 8'h10);
    wr(snhi_pkg::REG_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0));
    apb(1'b0, snhi_pkg::REG_STATUS, 32'h0000_0000, v);
    check(v[0], 1'b0, "quad refused");
    check(link_if.cs_n, 1'b1, "no select");
    // Select with hold bit low is kept off
    wr(snhi_pkg::REG_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0) & 32'hffff_ffbf);
    check(link_if.cs_n, 1'b1, "select with hold low");
    $display("test refusal done");
    // Guard bit with protect pin low locks protection, unless quad is on
    dev_set(1'b0, 8'h9c);
    check(prot_reg, 8'h9c, "protect open");
    wr(snhi_pkg::REG_CTRL, ctl(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0));
    repeat (4) @(posedge pclk);
    dev_set(1'b0, 8'h80);
    check(prot_reg, 8'h9c, "protect locked");
    dev_set(1'b1, 8'h11);
    dev_set(1'b0, 8'h80);
    check(prot_reg, 8'h80, "protect with quad");
    wr(snhi_pkg::REG_CTRL, ctl(1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0));
    $display("test protect done");
    // Address decode, with error correction on then off
    for (int k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      if (k % 12 == 0) begin
        dev_set(1'b1, (k == 0) ? 8'h10 : 8'h00);
      end
      c = (k % 12 < 8) ? corners[k % 12] : seed[11:0];
      column_addr <= c;
      row_addr <= {seed[0], lfsr(seed)};
      @(posedge pclk);
      check(col_valid, c <= snhi_pkg::COL_LAST, "column");
      check(spare_prog_ok, c < snhi_pkg::MAIN_BYTES + ((k < 12) ? snhi_pkg::SPARE_PROG_ECC :
        snhi_pkg::SPARE_BYTES), "spare");
      check(page_sel, row_addr[5:0], "page");
      check(block_sel, row_addr[16:6], "block");
    end
    $display("test address done");
    // Mode 3 link while the array reports busy work
    array_busy <= 1'b1;
    dev_set(1'b1, 8'h10);
    xfer(1'b1, 2'h0, 1'b0, 8'hc3);
    xfer(1'b1, 2'h0, 1'b1, 8'h5a);
    check(m3_seen, 1'b1, "mode 3 seen");
    check(array_busy_seen, 1'b1, "array work kept");
    $display("test mode 3 done");
    report_and_stop();
  end
endmodule
